//--- include/css_pkg.sv
package css_pkg;
  // Register layout of the oscillator-control and clock-mode registers
  localparam int         REG_W             = 4;
  localparam int         OSC_MAIN_EN_BIT   = 0;
  localparam int         OSC_RING_EN_BIT   = 1;
  localparam int         MODE_MAIN_SEL_BIT = 0;
  localparam logic [3:0] OSC_CTRL_RESET    = 4'h2;
  localparam logic [3:0] CLK_MODE_RESET    = 4'h0;

  // Power-down sequence states, Gray coded along run, armed, back-up
  typedef enum logic [1:0] {
    CSS_RUN    = 2'h0,
    CSS_ARMED  = 2'h1,
    CSS_BACKUP = 2'h3
  } css_pd_state_t;
endpackage : css_pkg

//--- design/css_once_latch.sv
`timescale 1ns/1ps
module css_once_latch (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_set,
  output logic      o_q
);
  logic q_reg;
  logic q_next;

  // Sets once and never clears except at hard reset
  always_comb begin
    q_next = q_reg | i_set;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_reg <= 1'b0;
    end else if (i_ce) begin
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;

  once_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q_reg |=> q_reg) else $error("One-time selection was lost");
  once_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !q_reg && i_ce && i_set |=> q_reg) else $error("One-time selection not taken");
endmodule : css_once_latch

//--- design/css_clock_select.sv
`timescale 1ns/1ps
// Summary of operation
// - RC oscillator select instruction takes effect once; later executions change nothing.
// - Without that instruction the ceramic circuit produces the main clock.
// - Return from back-up restores oscillator-control and clock-mode registers to initial.
// - The RC selection record survives the back-up state and its return.
// - Back-up entered only when power-down directly follows power-down enable.
module css_clock_select
  import css_pkg::*;
(
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RST_N,
  input  wire logic             I_CE,
  input  wire logic             I_INSTR_VALID,
  input  wire logic             I_RC_OSC_SELECT_INSTR,
  input  wire logic             I_POWER_DOWN_ENABLE_INSTR,
  input  wire logic             I_POWER_DOWN_INSTR,
  input  wire logic             I_WAKEUP,
  input  wire logic             I_OSC_CTRL_WE,
  input  wire logic [REG_W-1:0] I_OSC_CTRL_WDATA,
  input  wire logic             I_CLK_MODE_WE,
  input  wire logic [REG_W-1:0] I_CLK_MODE_WDATA,
  input  wire logic             I_MAIN_CLOCK,
  input  wire logic             I_RING_CLOCK,
  output logic      [REG_W-1:0] O_OSC_CTRL,
  output logic      [REG_W-1:0] O_CLK_MODE,
  output logic                  O_RC_OSC_SEL,
  output logic                  O_BACKUP,
  output logic                  O_MAIN_OSC_EN,
  output logic                  O_RING_OSC_EN,
  output logic                  O_MAIN_SEL,
  output logic                  O_SRC_CLK
);
  css_pd_state_t    state_reg;
  css_pd_state_t    state_next;
  logic [REG_W-1:0] osc_control_reg;
  logic [REG_W-1:0] osc_control_next;
  logic [REG_W-1:0] clock_mode_reg;
  logic [REG_W-1:0] clock_mode_next;
  logic             rc_set;
  logic             rc_sel;
  logic             wake_ev;
  logic             backup_reg;
  logic             backup_next;
  logic             main_en_reg;
  logic             main_en_next;
  logic             ring_en_reg;
  logic             ring_en_next;

  // Instructions count only outside back-up (run or armed), one per valid strobe
  assign rc_set  = I_INSTR_VALID && I_RC_OSC_SELECT_INSTR && (state_reg != CSS_BACKUP);
  assign wake_ev = (state_reg == CSS_BACKUP) && I_WAKEUP;

  // Sticky record, untouched by the back-up sequence
  css_once_latch css_once_latch_inst (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_set   (rc_set),
    .o_q     (rc_sel)
  );

  // Power-down sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSS_RUN: begin
        if (I_INSTR_VALID && I_POWER_DOWN_ENABLE_INSTR) begin
          state_next = CSS_ARMED;
        end
      end
      CSS_ARMED: begin
        if (I_INSTR_VALID) begin
          if (I_POWER_DOWN_INSTR) begin
            state_next = CSS_BACKUP;
          end else if (!I_POWER_DOWN_ENABLE_INSTR) begin
            state_next = CSS_RUN;
          end
        end
      end
      CSS_BACKUP: begin
        if (I_WAKEUP) begin
          state_next = CSS_RUN;
        end
      end
      default: begin
        state_next = CSS_RUN;
      end
    endcase
  end

  // Register writes; wake restores initial values
  always_comb begin
    osc_control_next = osc_control_reg;
    clock_mode_next  = clock_mode_reg;
    if (wake_ev) begin
      osc_control_next = OSC_CTRL_RESET;
      clock_mode_next  = CLK_MODE_RESET;
    end else if (state_reg != CSS_BACKUP) begin
      if (I_OSC_CTRL_WE) begin
        osc_control_next = I_OSC_CTRL_WDATA;
      end
      if (I_CLK_MODE_WE) begin
        clock_mode_next = I_CLK_MODE_WDATA;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg       <= CSS_RUN;
      osc_control_reg <= OSC_CTRL_RESET;
      clock_mode_reg  <= CLK_MODE_RESET;
    end else if (I_CE) begin
      state_reg       <= state_next;
      osc_control_reg <= osc_control_next;
      clock_mode_reg  <= clock_mode_next;
    end
  end

  // Output flags registered from next values; oscillators stop while backed up
  always_comb begin
    backup_next  = (state_next == CSS_BACKUP);
    main_en_next = osc_control_next[OSC_MAIN_EN_BIT] && !backup_next;
    ring_en_next = osc_control_next[OSC_RING_EN_BIT] && !backup_next;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      backup_reg  <= 1'b0;
      main_en_reg <= OSC_CTRL_RESET[OSC_MAIN_EN_BIT];
      ring_en_reg <= OSC_CTRL_RESET[OSC_RING_EN_BIT];
    end else if (I_CE) begin
      backup_reg  <= backup_next;
      main_en_reg <= main_en_next;
      ring_en_reg <= ring_en_next;
    end
  end

  assign O_OSC_CTRL    = osc_control_reg;
  assign O_CLK_MODE    = clock_mode_reg;
  assign O_RC_OSC_SEL  = rc_sel;
  assign O_BACKUP      = backup_reg;
  assign O_MAIN_OSC_EN = main_en_reg;
  assign O_RING_OSC_EN = ring_en_reg;
  assign O_MAIN_SEL    = clock_mode_reg[MODE_MAIN_SEL_BIT];
  // Operating source clock path
  assign O_SRC_CLK     = O_MAIN_SEL ? I_MAIN_CLOCK : I_RING_CLOCK;

  ceramic_default_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_RC_OSC_SEL |-> $past(O_RC_OSC_SEL) || $past(rc_set))
    else $error("RC selected without the select instruction");
  pd_entry_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    state_reg == CSS_ARMED && I_CE && I_INSTR_VALID && I_POWER_DOWN_INSTR |=> O_BACKUP)
    else $error("Power-down after enable did not enter back-up");
  pd_alone_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !O_BACKUP ##1 O_BACKUP |-> $past(state_reg) == CSS_ARMED)
    else $error("Back-up entered without enable first");
  wake_init_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    wake_ev && I_CE |=> !O_BACKUP && O_OSC_CTRL == OSC_CTRL_RESET
      && O_CLK_MODE == CLK_MODE_RESET)
    else $error("Registers not restored on return from back-up");
  rc_retained_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_BACKUP && O_RC_OSC_SEL |=> O_RC_OSC_SEL)
    else $error("RC selection lost across back-up");
  src_route_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_SRC_CLK == (clock_mode_reg[MODE_MAIN_SEL_BIT] ? I_MAIN_CLOCK : I_RING_CLOCK))
    else $error("Operating clock routed from wrong source");

  // Power-down sequence checks
  pd_arm_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    state_reg == CSS_RUN && I_CE && I_INSTR_VALID && I_POWER_DOWN_ENABLE_INSTR
      |=> state_reg == CSS_ARMED)
    else $error("Power-down enable did not arm the sequence");
  armed_keep_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    state_reg == CSS_ARMED && I_CE && I_INSTR_VALID && I_POWER_DOWN_ENABLE_INSTR
      && !I_POWER_DOWN_INSTR |=> state_reg == CSS_ARMED)
    else $error("Repeated power-down enable dropped the arming");
  pd_disarm_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    state_reg == CSS_ARMED && I_CE && I_INSTR_VALID && !I_POWER_DOWN_INSTR
      && !I_POWER_DOWN_ENABLE_INSTR |=> state_reg == CSS_RUN)
    else $error("Other instruction after enable did not disarm");
  backup_decode_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_BACKUP == (state_reg == CSS_BACKUP))
    else $error("Back-up flag disagrees with sequence state");
  state_freeze_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !I_CE |=> $stable(state_reg))
    else $error("Sequence state moved while clock enable low");
  osc_off_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_BACKUP |-> !O_MAIN_OSC_EN && !O_RING_OSC_EN)
    else $error("Oscillator left enabled in back-up");

  // Register and oscillator checks
  main_en_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !O_BACKUP |-> O_MAIN_OSC_EN == O_OSC_CTRL[OSC_MAIN_EN_BIT])
    else $error("Main oscillator enable disagrees with register");
  ring_en_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !O_BACKUP |-> O_RING_OSC_EN == O_OSC_CTRL[OSC_RING_EN_BIT])
    else $error("On-chip oscillator enable disagrees with register");
  osc_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    I_CE && !O_BACKUP && I_OSC_CTRL_WE |=> O_OSC_CTRL == $past(I_OSC_CTRL_WDATA))
    else $error("Oscillator-control write not taken");
  mode_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    I_CE && !O_BACKUP && I_CLK_MODE_WE |=> O_CLK_MODE == $past(I_CLK_MODE_WDATA))
    else $error("Clock-mode write not taken");
  backup_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_BACKUP && I_CE && !I_WAKEUP |=> $stable(O_OSC_CTRL) && $stable(O_CLK_MODE))
    else $error("Register changed during back-up");
  wake_ignored_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !O_BACKUP && I_CE && I_WAKEUP && !I_OSC_CTRL_WE && !I_CLK_MODE_WE
      |=> $stable(O_OSC_CTRL) && $stable(O_CLK_MODE))
    else $error("Wake outside back-up changed a register");
  reg_freeze_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !I_CE |=> $stable(O_OSC_CTRL) && $stable(O_CLK_MODE) && $stable(O_BACKUP))
    else $error("Register moved while clock enable low");
  rc_freeze_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !I_CE |=> $stable(O_RC_OSC_SEL))
    else $error("RC selection moved while clock enable low");
  rc_refused_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_BACKUP && !O_RC_OSC_SEL |=> !O_RC_OSC_SEL)
    else $error("RC select taken during back-up");
endmodule : css_clock_select

//--- verif/css_clock_select_tb.sv
`timescale 1ns/1ps
module css_clock_select_tb;
  import css_pkg::*;
  logic             clk = 1'b0, rst_n = 1'b0, ce = 1'b1, vld = 1'b0, rc = 1'b0, pde = 1'b0;
  logic             pd = 1'b0, wk = 1'b0, owe = 1'b0, mwe = 1'b0, mclk = 1'b0, rclk = 1'b0;
  logic [REG_W-1:0] owd = 4'h0, mwd = 4'h0, osc, mode;
  logic             rcs, bk, men, ren, msel, src;
  int               n_fail = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  css_clock_select css_clock_select_inst (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_INSTR_VALID(vld), .I_RC_OSC_SELECT_INSTR(rc), .I_POWER_DOWN_ENABLE_INSTR(pde),
    .I_POWER_DOWN_INSTR(pd), .I_WAKEUP(wk), .I_OSC_CTRL_WE(owe), .I_OSC_CTRL_WDATA(owd),
    .I_CLK_MODE_WE(mwe), .I_CLK_MODE_WDATA(mwd), .I_MAIN_CLOCK(mclk), .I_RING_CLOCK(rclk),
    .O_OSC_CTRL(osc), .O_CLK_MODE(mode), .O_RC_OSC_SEL(rcs), .O_BACKUP(bk),
    .O_MAIN_OSC_EN(men), .O_RING_OSC_EN(ren), .O_MAIN_SEL(msel), .O_SRC_CLK(src));
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Instruction {rc, enable, power-down}; all zero is some other instruction
  task automatic ins(input logic [2:0] c);
    @(posedge clk);
    vld <= 1'b1;
    {rc, pde, pd} <= c;
    @(posedge clk);
    vld <= 1'b0;
    {rc, pde, pd} <= 3'h0;
    #1;
  endtask : ins
  task automatic wr(input logic o, input logic [3:0] d);
    @(posedge clk);
    if (o) begin
      owe <= 1'b1;
      owd <= d;
    end else begin
      mwe <= 1'b1;
      mwd <= d;
    end
    @(posedge clk);
    owe <= 1'b0;
    mwe <= 1'b0;
    #1;
  endtask : wr
  task automatic t_reset;
    chk(osc, OSC_CTRL_RESET);
    chk(mode, CLK_MODE_RESET);
    chk({rcs, bk, men, ren}, 4'h1);
    chk({2'h0, msel, src}, {3'h0, rclk});
  endtask : t_reset
  task automatic t_mux;
    wr(1'b1, 4'h3);
    chk({2'h0, men, ren}, 4'h3);
    repeat (8) @(posedge clk);
    mclk <= 1'b1;
    wr(1'b0, 4'h1);
    chk({2'h0, msel, src}, 4'h3);
    @(posedge clk);
    mclk <= 1'b0;
    rclk <= 1'b1;
    #1;
    chk({2'h0, msel, src}, 4'h2);
    wr(1'b0, 4'h0);
    chk({2'h0, msel, src}, 4'h1);
  endtask : t_mux
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    ins(3'h2);
    wr(1'b0, 4'h1);
    chk({2'h0, msel, src}, 4'h1);
    @(posedge clk);
    ce <= 1'b1;
    ins(3'h1);
    chk({3'h0, bk}, 4'h0);
  endtask : t_ce
  task automatic t_rc;
    ins(3'h4);
    chk({3'h0, rcs}, 4'h1);
    ins(3'h4);
    chk({3'h0, rcs}, 4'h1);
  endtask : t_rc
  task automatic t_pd;
    ins(3'h1);
    chk({3'h0, bk}, 4'h0);
    ins(3'h2);
    ins(3'h0);
    ins(3'h1);
    chk({3'h0, bk}, 4'h0);
    wr(1'b0, 4'h1);
    wr(1'b1, 4'h1);
    ins(3'h2);
    ins(3'h1);
    chk({rcs, bk, men, ren}, 4'hc);
    wr(1'b1, 4'h3);
    chk(osc, 4'h1);
    @(posedge clk);
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    #1;
    chk(osc, OSC_CTRL_RESET);
    chk(mode, CLK_MODE_RESET);
    chk({rcs, bk, 1'b0, msel}, 4'h8);
  endtask : t_pd
  task automatic t_rst;
    wr(1'b1, 4'h3);
    wr(1'b0, 4'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
  endtask : t_rst
  task automatic results;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    #20000;
    n_fail++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_rc();
    t_mux();
    t_ce();
    t_pd();
    t_rst();
    results();
  end
endmodule : css_clock_select_tb
